// *** rtl/tmr8_core.sv ***
// 8-bit timer/counter with APB register access
`include "tmr8_regs.svh"
`default_nettype none
module tmr8_core #(
   parameter int PRESC_WIDTH = 10
) (
   input  wire logic       pclk,          // I/O clock, 100 MHz
   input  wire logic       presetn,       // Async reset, active low
   input  wire logic       psel,          // APB select
   input  wire logic       penable,       // APB access phase
   input  wire logic       pwrite,        // APB write
   input  wire logic [9:0] paddr,         // APB byte address
   input  wire logic [31:0] pwdata,       // APB write data
   input  wire logic [3:0] pstrb,         // APB byte strobes
   output logic [31:0]     prdata,        // APB read data
   output logic            pready,        // APB ready
   output logic            pslverr,       // APB error, unmapped
   input  wire logic       global_irq_en, // CPU global enable
   input  wire logic       ack_cmp_b,     // Compare B vector taken
   input  wire logic       ack_cmp_a,     // Compare A vector taken
   input  wire logic       ack_ovf,       // Overflow vector taken
   input  wire logic       ext_count_pin, // External count pin
   output logic            irq_cmp_b,     // Compare B request
   output logic            irq_cmp_a,     // Compare A request
   output logic            irq_ovf,       // Overflow request
   output logic            wave_out_a,    // Channel A waveform
   output logic            wave_out_b     // Channel B waveform
);
   if (PRESC_WIDTH < `TMR8_DIV1024_LOG) begin : g_bad_width
      $error("PRESC_WIDTH too small");
   end

   localparam logic [7:0] RST_CTRL_B = `TMR8_RST_CTRL_B;

   logic [7:0] control_reg_a_q;
   logic       wave_mode_top_bit_q;
   logic [2:0] clock_source_select_q;
   logic [2:0] irq_mask_q;
   logic [2:0] irq_flag_q;
   logic [7:0] counter_value_q;
   logic [7:0] compare_value_a_q;
   logic [7:0] compare_value_b_q;
   logic       count_up_q;
   logic       block_q;
   logic [1:0] force_q;
   logic [1:0] wave_q;
   logic [31:0] prdata_q;
   logic       pslverr_q;

   logic       tick;
   logic       setup, wr;
   logic [7:0] idx, wdat;
   tmr8_pkg::tmr8_mode_e mode;
   logic       top_from_a, pwm;
   logic [7:0] top;
   logic [1:0] match;
   logic       at_top, to_bottom, ovf_evt;
   logic [7:0] cnt_next;
   logic       up_next;

   function automatic logic mapped(input logic [7:0] i);
      case (i)
         `TMR8_IDX_CTRL_A, `TMR8_IDX_CNT, `TMR8_IDX_CTRL_B,
         `TMR8_IDX_CMP_A, `TMR8_IDX_FLAGS, `TMR8_IDX_MASK,
         `TMR8_IDX_CMP_B: mapped = 1'b1;
         default:         mapped = 1'b0;
      endcase
   endfunction : mapped

   function automatic tmr8_pkg::tmr8_mode_e decode_mode(
      input logic [2:0] wm);
      case (wm)
         3'h1, 3'h5: decode_mode = tmr8_pkg::MODE_PHASE_PWM;
         3'h2:       decode_mode = tmr8_pkg::MODE_CLEAR_ON_MATCH;
         3'h3, 3'h7: decode_mode = tmr8_pkg::MODE_FAST_PWM;
         default:    decode_mode = tmr8_pkg::MODE_NORMAL;
      endcase
   endfunction : decode_mode

   // Reserved codes 4 and 6 run as normal mode
   assign mode = decode_mode({wave_mode_top_bit_q,
      control_reg_a_q[`TMR8_A_WM_HI:`TMR8_A_WM_LO]});
   assign top_from_a = wave_mode_top_bit_q |
      (mode == tmr8_pkg::MODE_CLEAR_ON_MATCH);
   assign top = top_from_a ? compare_value_a_q : `TMR8_MAX;
   assign pwm = (mode == tmr8_pkg::MODE_PHASE_PWM) |
                (mode == tmr8_pkg::MODE_FAST_PWM);

   tmr8_tick #(
      .PRESC_WIDTH (PRESC_WIDTH)
   ) u_tick (
      .pclk                (pclk),
      .presetn             (presetn),
      .clock_source_select (clock_source_select_q),
      .ext_count_pin       (ext_count_pin),
      .tick                (tick)
   );

   // APB decode; zero wait states, data registered in setup
   assign idx    = paddr[9:2];
   assign wdat   = pwdata[7:0];
   assign setup  = psel & ~penable;
   assign wr     = psel & penable & pwrite & pstrb[0] & mapped(idx);
   assign pready = 1'b1;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= '0;
         pslverr_q <= 1'b0;
      end else if (setup) begin
         pslverr_q <= ~mapped(idx);
         prdata_q  <= '0;
         if (!pwrite) begin
            case (idx)
               `TMR8_IDX_CTRL_A: prdata_q[7:0] <= {control_reg_a_q[7:4],
                  2'h0, control_reg_a_q[1:0]};
               `TMR8_IDX_CTRL_B: prdata_q[7:0] <= {4'h0,
                  wave_mode_top_bit_q, clock_source_select_q};
               `TMR8_IDX_CNT:    prdata_q[7:0] <= counter_value_q;
               `TMR8_IDX_CMP_A:  prdata_q[7:0] <= compare_value_a_q;
               `TMR8_IDX_CMP_B:  prdata_q[7:0] <= compare_value_b_q;
               `TMR8_IDX_MASK:   prdata_q[7:0] <= {5'h0, irq_mask_q};
               `TMR8_IDX_FLAGS:  prdata_q[7:0] <= {5'h0, irq_flag_q};
               default:          prdata_q[7:0] <= 8'h00;
            endcase
         end
      end
   end

   // Control and compare registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_reg_a_q       <= `TMR8_RST_CTRL_A;
         wave_mode_top_bit_q   <= RST_CTRL_B[`TMR8_B_TOP_BIT];
         clock_source_select_q <= RST_CTRL_B[`TMR8_B_CS_HI:`TMR8_B_CS_LO];
         irq_mask_q            <= `TMR8_RST_MASK;
         compare_value_a_q     <= `TMR8_RST_CMP;
         compare_value_b_q     <= `TMR8_RST_CMP;
      end else if (wr) begin
         case (idx)
            `TMR8_IDX_CTRL_A: control_reg_a_q <= wdat;
            `TMR8_IDX_CTRL_B: begin
               wave_mode_top_bit_q   <= wdat[`TMR8_B_TOP_BIT];
               clock_source_select_q <= wdat[`TMR8_B_CS_HI:`TMR8_B_CS_LO];
            end
            `TMR8_IDX_MASK:   irq_mask_q <= wdat[2:0];
            `TMR8_IDX_CMP_A:  compare_value_a_q <= wdat;
            `TMR8_IDX_CMP_B:  compare_value_b_q <= wdat;
            default:          ;
         endcase
      end
   end

   // Force strobes live one cycle; PWM modes ignore them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         force_q <= 2'b00;
      end else if (wr && idx == `TMR8_IDX_CTRL_B && !pwm) begin
         force_q <= {wdat[`TMR8_B_FORCE_B],
                     wdat[`TMR8_B_FORCE_A]};
      end else begin
         force_q <= 2'b00;
      end
   end

   // Match ignores the tick right after a counter write
   assign match[0] = (counter_value_q == compare_value_a_q) & ~block_q;
   assign match[1] = (counter_value_q == compare_value_b_q) & ~block_q;
   assign at_top   = counter_value_q == top;

   always_comb begin
      cnt_next  = counter_value_q + 8'h01;
      up_next   = 1'b1;
      to_bottom = 1'b0;
      ovf_evt   = 1'b0;
      case (mode)
         tmr8_pkg::MODE_NORMAL: begin
            ovf_evt = counter_value_q == `TMR8_MAX;
         end
         tmr8_pkg::MODE_CLEAR_ON_MATCH: begin
            // Counter-only top check, so a force never clears it
            if (at_top) cnt_next = `TMR8_BOTTOM;
            to_bottom = at_top;
            ovf_evt   = counter_value_q == `TMR8_MAX;
         end
         tmr8_pkg::MODE_FAST_PWM: begin
            if (at_top) cnt_next = `TMR8_BOTTOM;
            to_bottom = at_top;
            ovf_evt   = at_top;
         end
         tmr8_pkg::MODE_PHASE_PWM: begin
            up_next = count_up_q;
            if (count_up_q && at_top) up_next = 1'b0;
            if (!count_up_q && counter_value_q == `TMR8_BOTTOM)
               up_next = 1'b1;
            cnt_next = up_next ? counter_value_q + 8'h01
                               : counter_value_q - 8'h01;
            ovf_evt  = !count_up_q && counter_value_q == `TMR8_BOTTOM;
         end
         default: ;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         counter_value_q <= `TMR8_RST_CNT;
         count_up_q      <= 1'b1;
         block_q         <= 1'b0;
      end else if (wr && idx == `TMR8_IDX_CNT) begin
         counter_value_q <= wdat;
         block_q         <= 1'b1;
      end else if (tick) begin
         counter_value_q <= cnt_next;
         count_up_q      <= up_next;
         block_q         <= 1'b0;
      end
   end

   // Flags: hardware set wins over software or vector clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_flag_q <= `TMR8_RST_FLAGS;
      end else begin
         for (int i = 0; i < 3; i++) begin
            logic set, clr;
            set = 1'b0;
            clr = wr && idx == `TMR8_IDX_FLAGS && wdat[i];
            case (i)
               `TMR8_BIT_OVF: begin
                  set = tick & ovf_evt;
                  clr = clr | ack_ovf;
               end
               `TMR8_BIT_CMP_A: begin
                  set = tick & match[0];
                  clr = clr | ack_cmp_a;
               end
               default: begin
                  set = tick & match[1];
                  clr = clr | ack_cmp_b;
               end
            endcase
            if (set)      irq_flag_q[i] <= 1'b1;
            else if (clr) irq_flag_q[i] <= 1'b0;
         end
      end
   end

   assign irq_ovf   = global_irq_en & irq_mask_q[`TMR8_BIT_OVF] &
                      irq_flag_q[`TMR8_BIT_OVF];
   assign irq_cmp_a = global_irq_en & irq_mask_q[`TMR8_BIT_CMP_A] &
                      irq_flag_q[`TMR8_BIT_CMP_A];
   assign irq_cmp_b = global_irq_en & irq_mask_q[`TMR8_BIT_CMP_B] &
                      irq_flag_q[`TMR8_BIT_CMP_B];

   // Next output level for one channel
   function automatic logic wave_next(
      input logic [1:0]           act,
      input logic                 cur,
      input tmr8_pkg::tmr8_mode_e md,
      input logic                 hit,
      input logic                 frc,
      input logic                 bot,
      input logic                 up,
      input logic                 top_hit,
      input logic                 tog_ok);
      wave_next = cur;
      case (md)
         tmr8_pkg::MODE_FAST_PWM: begin
            if (act == 2'b01) begin
               if (tog_ok && hit) wave_next = ~cur;
            end else if (act[1]) begin
               // Top equal to compare: only the bottom edge acts
               if (bot)                   wave_next = ~act[0];
               else if (hit && !top_hit) wave_next = act[0];
            end
         end
         tmr8_pkg::MODE_PHASE_PWM: begin
            if (act == 2'b01) begin
               if (tog_ok && hit) wave_next = ~cur;
            end else if (act[1] && hit) begin
               wave_next = up ? act[0] : ~act[0];
            end
         end
         default: begin
            if (hit || frc) begin
               case (act)
                  2'b01:   wave_next = ~cur;
                  2'b10:   wave_next = 1'b0;
                  2'b11:   wave_next = 1'b1;
                  default: wave_next = cur;
               endcase
            end
         end
      endcase
   endfunction : wave_next

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_wave
         logic [1:0] act;
         logic [7:0] cmp;
         assign act = (ch == 0)
            ? control_reg_a_q[`TMR8_A_ACT_A_HI:`TMR8_A_ACT_A_LO]
            : control_reg_a_q[`TMR8_A_ACT_B_HI:`TMR8_A_ACT_B_LO];
         assign cmp = (ch == 0) ? compare_value_a_q : compare_value_b_q;
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               wave_q[ch] <= 1'b0;
            end else if (tick || force_q[ch]) begin
               wave_q[ch] <= wave_next(act, wave_q[ch], mode,
                  tick & match[ch], force_q[ch], tick & to_bottom,
                  count_up_q, cmp == top,
                  (ch == 0) & wave_mode_top_bit_q);
            end
         end
      end
   endgenerate

   assign wave_out_a = wave_q[0];
   assign wave_out_b = wave_q[1];
endmodule : tmr8_core
`default_nettype wire

// *** rtl/tmr8_regs.svh ***
// Register indices, field positions, reset values and prescaler figures
`ifndef TMR8_REGS_SVH
`define TMR8_REGS_SVH
// Register indices; byte address is four times the index
`define TMR8_IDX_CTRL_A    8'h30
`define TMR8_IDX_CNT       8'h32
`define TMR8_IDX_CTRL_B    8'h33
`define TMR8_IDX_CMP_A     8'h36
`define TMR8_IDX_FLAGS     8'h38
`define TMR8_IDX_MASK      8'h39
`define TMR8_IDX_CMP_B     8'h3C
// Control register B fields
`define TMR8_B_FORCE_A     7
`define TMR8_B_FORCE_B     6
`define TMR8_B_TOP_BIT     3
`define TMR8_B_CS_HI       2
`define TMR8_B_CS_LO       0
// Control register A fields
`define TMR8_A_ACT_A_HI    7
`define TMR8_A_ACT_A_LO    6
`define TMR8_A_ACT_B_HI    5
`define TMR8_A_ACT_B_LO    4
`define TMR8_A_WM_HI       1
`define TMR8_A_WM_LO       0
// Mask and flag bit positions
`define TMR8_BIT_CMP_B     2
`define TMR8_BIT_CMP_A     1
`define TMR8_BIT_OVF       0
// Reset values
`define TMR8_RST_CTRL_A    8'h00
`define TMR8_RST_CTRL_B    8'h00
`define TMR8_RST_MASK      3'h0
`define TMR8_RST_FLAGS     3'h0
`define TMR8_RST_CNT       8'h00
`define TMR8_RST_CMP       8'h00
// Fixed count limits
`define TMR8_MAX           8'hFF
`define TMR8_BOTTOM        8'h00
// Prescaler taps as log2 of the division
`define TMR8_DIV8_LOG      3
`define TMR8_DIV64_LOG     6
`define TMR8_DIV256_LOG    8
`define TMR8_DIV1024_LOG   10
`endif

// *** rtl/tmr8_pkg.sv ***
// Types shared by the timer files
`default_nettype none
package tmr8_pkg;
   typedef enum logic [2:0] {
      CS_STOP, CS_DIV1, CS_DIV8, CS_DIV64,
      CS_DIV256, CS_DIV1024, CS_EXT_FALL, CS_EXT_RISE
   } tmr8_cs_e;
   typedef enum {
      MODE_NORMAL, MODE_PHASE_PWM, MODE_CLEAR_ON_MATCH, MODE_FAST_PWM
   } tmr8_mode_e;
   typedef logic [7:0] tmr8_byte_t;
endpackage : tmr8_pkg
`default_nettype wire

// *** rtl/tmr8_tick.sv ***
// Clock source select: prescaler taps and external count pin edges
`include "tmr8_regs.svh"
`default_nettype none
module tmr8_tick #(
   parameter int PRESC_WIDTH = 10
) (
   input  wire logic       pclk,          // I/O clock
   input  wire logic       presetn,       // Async reset, active low
   input  wire logic [2:0] clock_source_select, // Source code
   input  wire logic       ext_count_pin, // External count pin level
   output logic            tick           // One-cycle count pulse
);
   if (PRESC_WIDTH < `TMR8_DIV1024_LOG) begin : g_bad_width
      $error("PRESC_WIDTH too small for the 1024 tap");
   end

   logic [PRESC_WIDTH-1:0] presc_q;
   logic                   sync1_q, sync2_q, sync3_q, lvl_q, lvl_prev_q;
   logic                   rise, fall;

   // Free running so a source change never waits a full wrap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) presc_q <= '0;
      else          presc_q <= presc_q + 1'b1;
   end

   // Pin is sampled even when driven by this chip as an output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q    <= 1'b0;
         sync2_q    <= 1'b0;
         sync3_q    <= 1'b0;
         lvl_q      <= 1'b0;
         lvl_prev_q <= 1'b0;
      end else begin
         sync1_q    <= ext_count_pin;
         sync2_q    <= sync1_q;
         sync3_q    <= sync2_q;
         if (sync2_q == sync3_q) lvl_q <= sync3_q;
         lvl_prev_q <= lvl_q;
      end
   end

   assign rise = lvl_q & ~lvl_prev_q;
   assign fall = ~lvl_q & lvl_prev_q;

   function automatic logic tap(input logic [PRESC_WIDTH-1:0] p,
                                input int lg);
      logic [PRESC_WIDTH-1:0] m;
      m   = (PRESC_WIDTH)'((1 << lg) - 1);
      tap = (p & m) == m;
   endfunction : tap

   always_comb begin
      case (tmr8_pkg::tmr8_cs_e'(clock_source_select))
         tmr8_pkg::CS_STOP:     tick = 1'b0;
         tmr8_pkg::CS_DIV1:     tick = 1'b1;
         tmr8_pkg::CS_DIV8:     tick = tap(presc_q, `TMR8_DIV8_LOG);
         tmr8_pkg::CS_DIV64:    tick = tap(presc_q, `TMR8_DIV64_LOG);
         tmr8_pkg::CS_DIV256:   tick = tap(presc_q, `TMR8_DIV256_LOG);
         tmr8_pkg::CS_DIV1024:  tick = tap(presc_q, `TMR8_DIV1024_LOG);
         tmr8_pkg::CS_EXT_FALL: tick = fall;
         tmr8_pkg::CS_EXT_RISE: tick = rise;
         default:               tick = 1'b0;
      endcase
   end
endmodule : tmr8_tick
`default_nettype wire

// *** verif/tmr8_core_chk.sv ***
// Port checker for the timer core, bound to every instance
`include "tmr8_regs.svh"
`default_nettype none
module tmr8_core_chk #(
   parameter int PRESC_WIDTH = 10
) (
   input wire logic        pclk,          // Clock
   input wire logic        presetn,       // Reset, low
   input wire logic        psel,          // Select
   input wire logic        penable,       // Access
   input wire logic        pwrite,        // Write
   input wire logic [9:0]  paddr,         // Address
   input wire logic [31:0] pwdata,        // Write data
   input wire logic [3:0]  pstrb,         // Strobes
   input wire logic [31:0] prdata,        // Read data
   input wire logic        pready,        // Ready
   input wire logic        pslverr,       // Error
   input wire logic        global_irq_en, // Global enable
   input wire logic        ack_cmp_b,     // Ack B
   input wire logic        ack_cmp_a,     // Ack A
   input wire logic        ack_ovf,       // Ack ovf
   input wire logic        ext_count_pin, // Pin
   input wire logic        irq_cmp_b,     // Irq B
   input wire logic        irq_cmp_a,     // Irq A
   input wire logic        irq_ovf,       // Irq ovf
   input wire logic        wave_out_a,    // Wave A
   input wire logic        wave_out_b     // Wave B
);
   logic [7:0]      ctl_a_q;
   logic [2:0]      cs_q;
   logic [2:0]      mask_q;
   wire logic [7:0] idx = paddr[9:2];
   wire logic       wr = psel && penable && pwrite && pstrb[0];
   wire logic       rd_setup = psel && !penable && !pwrite;
   wire logic       mapped = idx inside {`TMR8_IDX_CTRL_A, `TMR8_IDX_CNT,
      `TMR8_IDX_CTRL_B, `TMR8_IDX_CMP_A, `TMR8_IDX_FLAGS, `TMR8_IDX_MASK,
      `TMR8_IDX_CMP_B};
   // Shadows of the fields that decide what a force or a request does
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ctl_a_q <= 8'h00;
      else if (wr && idx == `TMR8_IDX_CTRL_A) ctl_a_q <= pwdata[7:0];
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cs_q <= 3'h0;
      else if (wr && idx == `TMR8_IDX_CTRL_B) cs_q <= pwdata[2:0];
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) mask_q <= 3'h0;
      else if (wr && idx == `TMR8_IDX_MASK) mask_q <= pwdata[2:0];
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Stopped timer only, so no real match can move the output too
   sequence s_force_a;
      wr && idx == `TMR8_IDX_CTRL_B && pwdata[7] && pwdata[2:0] == 3'h0
         && cs_q == 3'h0 && !ctl_a_q[0] && ctl_a_q[7:6] == 2'h1;
   endsequence
   sequence s_force_b;
      wr && idx == `TMR8_IDX_CTRL_B && pwdata[6] && pwdata[2:0] == 3'h0
         && cs_q == 3'h0 && !ctl_a_q[0] && ctl_a_q[5:4] == 2'h1;
   endsequence
   a_force_a_toggle: assert property (
      s_force_a |-> ##2 wave_out_a != $past(wave_out_a, 2))
      else $error("forced compare A did not toggle output A");
   a_force_b_toggle: assert property (
      s_force_b |-> ##2 wave_out_b != $past(wave_out_b, 2))
      else $error("forced compare B did not toggle output B");
   a_err_unmapped: assert property (
      psel && !penable && !mapped |=> pslverr)
      else $error("unmapped access without error");
   a_read_ctlb: assert property (
      rd_setup && idx == `TMR8_IDX_CTRL_B |=> prdata[7:4] == 4'h0)
      else $error("control B upper bits not zero");
   a_read_irq_regs: assert property (
      rd_setup && idx inside {`TMR8_IDX_MASK, `TMR8_IDX_FLAGS}
      |=> prdata[7:3] == 5'h00)
      else $error("mask or flag reserved bits not zero");
   a_rdata_high: assert property (psel && penable |-> prdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   a_gate_cmp_b: assert property (
      irq_cmp_b |-> global_irq_en && mask_q[2])
      else $error("compare B request without enables");
   a_gate_cmp_a: assert property (
      irq_cmp_a |-> global_irq_en && mask_q[1])
      else $error("compare A request without enables");
   a_gate_ovf: assert property (
      irq_ovf |-> global_irq_en && mask_q[0])
      else $error("overflow request without enables");
endmodule : tmr8_core_chk
bind tmr8_core tmr8_core_chk #(.PRESC_WIDTH(PRESC_WIDTH)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .global_irq_en(global_irq_en), .ack_cmp_b(ack_cmp_b),
   .ack_cmp_a(ack_cmp_a), .ack_ovf(ack_ovf), .ext_count_pin(ext_count_pin),
   .irq_cmp_b(irq_cmp_b), .irq_cmp_a(irq_cmp_a), .irq_ovf(irq_ovf),
   .wave_out_a(wave_out_a), .wave_out_b(wave_out_b));
`default_nettype wire

// *** verif/tmr8_cpu_model.sv ***
// CPU side model that takes interrupt vectors
`default_nettype none
module tmr8_cpu_model (
   input  wire logic       pclk,     // Clock
   input  wire logic       presetn,  // Reset, low
   input  wire logic       auto_ack, // Take vectors
   input  wire logic [2:0] irq_v,    // B, A, overflow requests
   output logic [2:0]      ack_v     // Vector taken pulses
);
   timeunit 1ns;
   timeprecision 1ps;
   // One pulse per request; the gap lets the flag drop before a retake
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ack_v <= 3'h0;
      else ack_v <= irq_v & ~ack_v & {3{auto_ack}};
   end
endmodule : tmr8_cpu_model
`default_nettype wire

// *** verif/timer8_control_and_interrupts_tb.sv ***
// Register level tests of the timer core
`include "tmr8_regs.svh"
`default_nettype none
module timer8_control_and_interrupts_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] r_cnt = `TMR8_IDX_CNT;
   localparam logic [7:0] r_cb = `TMR8_IDX_CTRL_B;
   localparam logic [7:0] r_fl = `TMR8_IDX_FLAGS;
   localparam logic [7:0] r_mk = `TMR8_IDX_MASK;
   logic [7:0]  regs [7] = '{`TMR8_IDX_CTRL_A, r_cnt, r_cb, `TMR8_IDX_CMP_A,
                             r_fl, r_mk, `TMR8_IDX_CMP_B};
   int          lg [5] = '{0, `TMR8_DIV8_LOG, `TMR8_DIV64_LOG,
                           `TMR8_DIV256_LOG, `TMR8_DIV1024_LOG};
   logic        pclk, presetn, psel, penable, pwrite, glob, auto_ack, ext_pin;
   logic [9:0]  paddr;
   logic [31:0] pwdata, rd;
   logic [3:0]  pstrb;
   wire logic [31:0] prdata;
   wire logic   pready, pslverr, wave_a, wave_b;
   wire logic [2:0] irq_v, ack_v;
   logic        err, wa, wb;
   int          fail_count, compares, cycles;
   tmr8_core #(.PRESC_WIDTH(10)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .global_irq_en(glob), .ack_cmp_b(ack_v[2]), .ack_cmp_a(ack_v[1]),
      .ack_ovf(ack_v[0]), .ext_count_pin(ext_pin), .irq_cmp_b(irq_v[2]),
      .irq_cmp_a(irq_v[1]), .irq_ovf(irq_v[0]), .wave_out_a(wave_a),
      .wave_out_b(wave_b));
   tmr8_cpu_model cpu (.pclk(pclk), .presetn(presetn), .auto_ack(auto_ack),
      .irq_v(irq_v), .ack_v(ack_v));
   always #5 pclk = ~pclk;
   task automatic close_out;
      if (fail_count == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : close_out
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         close_out();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Idle cycle between transfers keeps each signal to one update per step
   task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic rdchk(input logic [7:0] i, input logic [7:0] exp);
      xfer(1'b0, i, 8'h00);
      check(rd, {24'h0, exp});
   endtask : rdchk
   task automatic run(input logic [7:0] cs, input logic [7:0] s, input int n);
      xfer(1'b1, r_cnt, s);
      xfer(1'b1, r_cb, cs);
      repeat (n) @(posedge pclk);
      xfer(1'b1, r_cb, 8'h00);
   endtask : run
   task automatic settle;
      @(posedge pclk);
      @(negedge pclk);
   endtask : settle
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, glob, auto_ack, ext_pin} = 6'h00;
      paddr = 10'h000;
      pwdata = 32'h0;
      pstrb = 4'hF;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      foreach (regs[i]) rdchk(regs[i], 8'h00);
      check({irq_v, wave_a, wave_b}, 32'h0);
      xfer(1'b0, 8'h31, 8'h00);
      check({err, rd[7:0]}, 32'h100);
      xfer(1'b1, r_cb, 8'hCF);
      rdchk(r_cb, 8'h0F);
      xfer(1'b1, r_mk, 8'hFF);
      rdchk(r_mk, 8'h07);
      xfer(1'b1, r_fl, 8'hFF);
      rdchk(r_fl, 8'h00);
      xfer(1'b1, r_cb, 8'h00);
      xfer(1'b1, r_mk, 8'h00);
      xfer(1'b1, r_cnt, 8'h5A);
      rdchk(r_cnt, 8'h5A);
      xfer(1'b1, regs[3], 8'hA5);
      rdchk(regs[3], 8'hA5);
      xfer(1'b1, regs[6], 8'h3C);
      rdchk(regs[6], 8'h3C);
      for (int i = 0; i < 5; i++) begin
         run(i + 1, 8'h00, 4 << lg[i]);
         xfer(1'b0, r_cnt, 8'h00);
         check(rd >= 4 && rd <= 8, 1'b1);
      end
      xfer(1'b1, r_cnt, 8'h33);
      repeat (20) @(posedge pclk);
      rdchk(r_cnt, 8'h33);
      for (int e = 6; e < 8; e++) begin
         run(e, 8'h00, 0);
         xfer(1'b1, r_cb, e);
         repeat (3) begin
            ext_pin <= 1'b1;
            repeat (8) @(posedge pclk);
            ext_pin <= 1'b0;
            repeat (8) @(posedge pclk);
         end
         xfer(1'b1, r_cb, 8'h00);
         rdchk(r_cnt, 8'h03);
      end
      for (int b = 0; b < 3; b++) begin
         xfer(1'b1, r_fl, 8'h07);
         if (b > 0) begin
            xfer(1'b1, regs[b * 3], 8'h10);
            run(8'h01, 8'h10, 3);
            rdchk(r_fl, 8'h00);
         end
         run(8'h01, b == 0 ? 8'hF8 : 8'h0C, 10);
         xfer(1'b0, r_fl, 8'h00);
         check(rd[b], 1'b1);
         glob <= 1'b1;
         xfer(1'b1, r_mk, 8'h01 << b);
         settle();
         check(irq_v, 3'h1 << b);
         @(posedge pclk);
         glob <= 1'b0;
         @(negedge pclk);
         check(irq_v, 3'h0);
         xfer(1'b1, r_fl, 8'h00);
         xfer(1'b0, r_fl, 8'h00);
         check(rd[b], 1'b1);
         xfer(1'b1, r_fl, 8'h01 << b);
         xfer(1'b0, r_fl, 8'h00);
         check(rd[b], 1'b0);
         run(8'h01, b == 0 ? 8'hF8 : 8'h0C, 10);
         glob <= 1'b1;
         auto_ack <= 1'b1;
         repeat (6) @(posedge pclk);
         auto_ack <= 1'b0;
         @(negedge pclk);
         check(irq_v, 3'h0);
         xfer(1'b0, r_fl, 8'h00);
         check(rd[b], 1'b0);
         glob <= 1'b0;
      end
      xfer(1'b1, regs[0], 8'h52);
      xfer(1'b1, r_cnt, 8'h20);
      xfer(1'b1, regs[3], 8'h20);
      xfer(1'b1, r_fl, 8'h07);
      settle();
      wa = wave_a;
      wb = wave_b;
      xfer(1'b1, r_cb, 8'h80);
      settle();
      check({wave_a, wave_b}, {~wa, wb});
      xfer(1'b1, r_cb, 8'h40);
      settle();
      check({wave_a, wave_b}, {~wa, ~wb});
      rdchk(r_cnt, 8'h20);
      rdchk(r_fl, 8'h00);
      rdchk(r_cb, 8'h00);
      // Fast PWM, inverting A: top wraps, overflow set, A cleared at bottom
      xfer(1'b1, regs[0], 8'hC3);
      run(8'h01, 8'hFE, 0);
      rdchk(r_cnt, 8'h01);
      rdchk(r_fl, 8'h01);
      check(wave_a, 1'b0);
      close_out();
   end
endmodule : timer8_control_and_interrupts_tb
`default_nettype wire
